// ==== logic/tac_pkg.sv ====
// Package for the touch panel and converter control block
package tac_pkg;
	// Register byte addresses are the register index times four
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h62;
	localparam logic [7:0] IDX_PANEL_CTRL = 8'h64;
	localparam logic [7:0] IDX_CONV_CTRL = 8'h66;
	localparam logic [7:0] IDX_CONV_RESULT = 8'h68;
	localparam logic [7:0] IDX_POS_EDGE_EN = 8'h5e;
	localparam logic [7:0] IDX_NEG_EDGE_EN = 8'h60;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h70;
	localparam logic [9:0] ADR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [9:0] ADR_PANEL_CTRL = {IDX_PANEL_CTRL, 2'b00};
	localparam logic [9:0] ADR_CONV_CTRL = {IDX_CONV_CTRL, 2'b00};
	localparam logic [9:0] ADR_CONV_RESULT = {IDX_CONV_RESULT, 2'b00};
	localparam logic [9:0] ADR_POS_EDGE_EN = {IDX_POS_EDGE_EN, 2'b00};
	localparam logic [9:0] ADR_NEG_EDGE_EN = {IDX_NEG_EDGE_EN, 2'b00};
	localparam logic [9:0] ADR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
	// Field positions
	localparam int IRQ_OVR_BIT = 15;
	localparam int IRQ_SAT_BIT = 14;
	localparam int IRQ_XNEG_BIT = 13;
	localparam int IRQ_XPOS_BIT = 12;
	localparam int IRQ_READY_BIT = 11;
	localparam int PNL_XNEG_LVL_BIT = 13;
	localparam int PNL_XPOS_LVL_BIT = 12;
	localparam int CNV_DONE_BIT = 15;
	// Writable masks
	localparam logic [15:0] IRQ_IMPL_MASK = 16'hfbff;
	localparam logic [15:0] PANEL_RW_MASK = 16'h0fff;
	localparam logic [15:0] CONV_RW_MASK = 16'h803f;
	// Reset values
	localparam logic [15:0] RST_ZERO16 = 16'h0000;
	localparam logic [9:0] RST_ZERO10 = 10'h000;
	// Cycle count of one conversion
	localparam logic [4:0] CONV_CYCLES = 5'h14;

	typedef enum logic [3:0] {
		CS_OFF = 4'b0001,
		CS_IDLE = 4'b0010,
		CS_ARMED = 4'b0100,
		CS_CONV = 4'b1000
	} tac_conv_state_t;

	typedef enum logic [1:0] {
		PM_IRQ = 2'b00,
		PM_PRESSURE = 2'b01,
		PM_POSITION = 2'b10
	} tac_panel_mode_t;

	typedef struct packed {
		logic yplus_ground;
		logic yminus_ground;
		logic xplus_ground;
		logic xminus_ground;
		logic yplus_power;
		logic yminus_power;
		logic xplus_power;
		logic xminus_power;
	} tac_pin_drive_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [9:0] adr;
		logic [31:0] dat;
	} tac_wb_req_t;

	typedef struct packed {
		logic ack;
		logic irq;
		logic [31:0] rdata;
		logic [15:0] irq_status;
		logic [15:0] irq_mask;
		logic [15:0] pos_en;
		logic [15:0] neg_en;
		logic [11:0] panel_ctrl;
		logic converter_power_on;
		logic test_ext_voltage;
		logic [2:0] conv_input_select;
		logic reference_bypass;
		logic sync_trigger_select;
		logic conv_done;
		logic [9:0] conv_result;
		tac_conv_state_t conv_state;
		logic [4:0] conv_count;
		logic [15:0] src_prev;
		logic sync_prev;
		logic conv_sample;
		tac_pin_drive_t pins;
	} tac_state_t;
endpackage

// ==== logic/tac_touch_adc_control.sv ====
// Touch panel and readout converter control with Wishbone registers
`timescale 1ns/10ps
module tac_touch_adc_control import tac_pkg::*; (
	input wire logic MCLK, // 125 MHz clock
	input wire logic RST, // Asynchronous reset, active high
	input wire logic WB_CYC_I, // Wishbone cycle
	input wire logic WB_STB_I, // Wishbone strobe
	input wire logic WB_WE_I, // Wishbone write enable
	input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
	input wire logic [9:0] WB_ADR_I, // Wishbone byte address
	input wire logic [31:0] WB_DAT_I, // Wishbone write data
	output logic [31:0] WB_DAT_O, // Wishbone read data
	output logic WB_ACK_O, // Wishbone acknowledge
	output logic IRQ, // Level interrupt
	input wire logic X_MINUS_PIN_LVL, // Level on the X-minus panel pin
	input wire logic X_PLUS_PIN_LVL, // Level on the X-plus panel pin
	input wire logic CONVERTER_OVERRANGE, // Converter overflow signal
	input wire logic AUDIO_SATURATION, // Audio audio_saturation signal
	input wire logic [9:0] GPIO_LVL, // General-purpose pin levels
	input wire logic CONV_SYNC_PIN, // External conversion sync
	input wire logic [9:0] CONV_SAMPLE, // Converter output word
	output logic YPLUS_GROUND, // Ground Y-plus pin
	output logic YMINUS_GROUND, // Ground Y-minus pin
	output logic XPLUS_GROUND, // Ground X-plus pin
	output logic XMINUS_GROUND, // Ground X-minus pin
	output logic YPLUS_POWER, // Power Y-plus pin
	output logic YMINUS_POWER, // Power Y-minus pin
	output logic XPLUS_POWER, // Power X-plus pin
	output logic XMINUS_POWER, // Power X-minus pin
	output logic PANEL_BIAS_EN, // Panel bias circuitry on
	output logic SCHMITT_HYST_OFF, // Hysteresis disabled
	output logic MODE_IRQ, // Panel in interrupt mode
	output logic MODE_PRESSURE, // Panel in pressure mode
	output logic MODE_POSITION, // Panel in position mode
	output logic CONVERTER_POWER_ON, // Converter powered
	output logic [7:0] CONV_INPUT_ONEHOT, // Converter input route
	output logic REFERENCE_BYPASS_EN, // Reference to bypass pin
	output logic TEST_EXT_VOLTAGE, // Test bit passed through
	output logic CONV_SAMPLE_REQ // Converter sampling active
);
	tac_state_t s_q, s_d;
	logic [15:0] src_now;
	logic [15:0] rise, fall, ev;
	logic [15:0] wmask;
	logic wr, rd_hit, start_req;
	logic [15:0] rval;
	tac_panel_mode_t pmode;

	always_comb begin
		s_d = s_q;
		wmask = {(WB_SEL_I[1] ? 8'hff : 8'h00), (WB_SEL_I[0] ? 8'hff : 8'h00)};
		wr = WB_CYC_I && WB_STB_I && WB_WE_I && !s_q.ack;
		start_req = 1'b0;
		// Event sources in status-bit order; ready is the done flag
		src_now = {CONVERTER_OVERRANGE, AUDIO_SATURATION, X_MINUS_PIN_LVL, X_PLUS_PIN_LVL,
			s_q.conv_done, 1'b0, GPIO_LVL};
		rise = src_now & ~s_q.src_prev & s_q.pos_en;
		fall = ~src_now & s_q.src_prev & s_q.neg_en;
		ev = (rise | fall) & IRQ_IMPL_MASK;
		s_d.src_prev = src_now;
		s_d.sync_prev = CONV_SYNC_PIN;
		s_d.ack = WB_CYC_I && WB_STB_I && !s_q.ack;
		rd_hit = 1'b1;
		rval = RST_ZERO16;
		unique case (WB_ADR_I)
			ADR_IRQ_STATUS: rval = s_q.irq_status;
			ADR_PANEL_CTRL: rval = {2'b00, X_MINUS_PIN_LVL, X_PLUS_PIN_LVL,
				s_q.panel_ctrl};
			ADR_CONV_CTRL: rval = {s_q.converter_power_on, 7'h00,
				s_q.conv_state == CS_ARMED, 1'b0, s_q.test_ext_voltage,
				s_q.conv_input_select, s_q.reference_bypass, s_q.sync_trigger_select};
			ADR_CONV_RESULT: rval = {s_q.conv_done, 5'h00, s_q.conv_result};
			ADR_POS_EDGE_EN: rval = s_q.pos_en;
			ADR_NEG_EDGE_EN: rval = s_q.neg_en;
			ADR_IRQ_MASK: rval = s_q.irq_mask;
			default: rd_hit = 1'b0;
		endcase
		if (WB_CYC_I && WB_STB_I && !s_q.ack) begin
			s_d.rdata = {16'h0000, rd_hit ? rval : RST_ZERO16};
		end
		// Write-one-to-clear, then new events win over the clear
		if (wr && WB_ADR_I == ADR_IRQ_STATUS) begin
			s_d.irq_status = s_q.irq_status & ~(WB_DAT_I[15:0] & wmask);
		end
		if (wr) begin
			unique case (WB_ADR_I)
				ADR_PANEL_CTRL: s_d.panel_ctrl = (s_q.panel_ctrl & ~wmask[11:0]) |
					(WB_DAT_I[11:0] & wmask[11:0] & PANEL_RW_MASK[11:0]);
				ADR_CONV_CTRL: begin
					if (WB_SEL_I[1]) begin
						s_d.converter_power_on = WB_DAT_I[15];
					end
					if (WB_SEL_I[0]) begin
						s_d.test_ext_voltage = WB_DAT_I[5];
						s_d.conv_input_select = WB_DAT_I[4:2];
						s_d.reference_bypass = WB_DAT_I[1];
						s_d.sync_trigger_select = WB_DAT_I[0];
						start_req = WB_DAT_I[7];
					end
				end
				ADR_POS_EDGE_EN: s_d.pos_en = ((s_q.pos_en & ~wmask) | (WB_DAT_I[15:0] & wmask))
					& IRQ_IMPL_MASK;
				ADR_NEG_EDGE_EN: s_d.neg_en = ((s_q.neg_en & ~wmask) | (WB_DAT_I[15:0] & wmask))
					& IRQ_IMPL_MASK;
				ADR_IRQ_MASK: s_d.irq_mask = ((s_q.irq_mask & ~wmask) | (WB_DAT_I[15:0] & wmask))
					& IRQ_IMPL_MASK;
				default: ;
			endcase
		end
		s_d.irq_status = s_d.irq_status | ev;
		s_d.irq = |(s_d.irq_status & s_d.irq_mask);
		// Conversion sequencer
		s_d.conv_sample = 1'b0;
		unique case (s_q.conv_state)
			CS_OFF: begin
				if (s_q.converter_power_on) begin
					s_d.conv_state = CS_IDLE;
				end
			end
			CS_IDLE: begin
				if (start_req) begin
					if (s_d.sync_trigger_select) begin
						s_d.conv_state = CS_ARMED;
					end else begin
						s_d.conv_state = CS_CONV;
						s_d.conv_done = 1'b0;
						s_d.conv_count = CONV_CYCLES;
					end
				end
			end
			CS_ARMED: begin
				if (CONV_SYNC_PIN && !s_q.sync_prev) begin
					s_d.conv_state = CS_CONV;
					s_d.conv_done = 1'b0;
					s_d.conv_count = CONV_CYCLES;
				end
			end
			CS_CONV: begin
				s_d.conv_sample = 1'b1;
				if (s_q.conv_count == 5'h01) begin
					s_d.conv_state = CS_IDLE;
					s_d.conv_result = CONV_SAMPLE;
					s_d.conv_done = 1'b1;
					s_d.conv_sample = 1'b0;
				end else begin
					s_d.conv_count = s_q.conv_count - 5'h01;
				end
			end
			default: s_d.conv_state = CS_OFF;
		endcase
		if (!s_d.converter_power_on) begin
			s_d.conv_state = CS_OFF;
			s_d.conv_sample = 1'b0;
		end
		s_d.pins = tac_pin_drive_t'(s_d.panel_ctrl[7:0]);
		pmode = s_d.panel_ctrl[9] ? PM_POSITION : tac_panel_mode_t'(s_d.panel_ctrl[9:8]);
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s_q <= '{conv_state: CS_OFF, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Mode and input route outputs registered separately from the state struct copy
	logic [2:0] mode_q;
	logic [7:0] route_q;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			mode_q <= 3'h1;
			route_q <= 8'h01;
		end else begin
			mode_q <= {pmode == PM_POSITION, pmode == PM_PRESSURE, pmode == PM_IRQ};
			route_q <= 8'h01 << s_d.conv_input_select;
		end
	end

	assign WB_DAT_O = s_q.rdata;
	assign WB_ACK_O = s_q.ack;
	assign IRQ = s_q.irq;
	assign YPLUS_GROUND = s_q.pins.yplus_ground;
	assign YMINUS_GROUND = s_q.pins.yminus_ground;
	assign XPLUS_GROUND = s_q.pins.xplus_ground;
	assign XMINUS_GROUND = s_q.pins.xminus_ground;
	assign YPLUS_POWER = s_q.pins.yplus_power;
	assign YMINUS_POWER = s_q.pins.yminus_power;
	assign XPLUS_POWER = s_q.pins.xplus_power;
	assign XMINUS_POWER = s_q.pins.xminus_power;
	assign PANEL_BIAS_EN = s_q.panel_ctrl[11];
	assign SCHMITT_HYST_OFF = s_q.panel_ctrl[10];
	assign MODE_IRQ = mode_q[0];
	assign MODE_PRESSURE = mode_q[1];
	assign MODE_POSITION = mode_q[2];
	assign CONVERTER_POWER_ON = s_q.converter_power_on;
	assign CONV_INPUT_ONEHOT = route_q;
	assign REFERENCE_BYPASS_EN = s_q.reference_bypass;
	assign TEST_EXT_VOLTAGE = s_q.test_ext_voltage;
	assign CONV_SAMPLE_REQ = s_q.conv_sample;
endmodule

// ==== verif/tac_panel_model.sv ====
// Behavioural model of the resistive panel and converter front end
`timescale 1ns/10ps
module tac_panel_model (
	input wire logic mclk, // Clock
	input wire logic pen_down, // Pen pressed
	input wire logic power_on, // Converter powered
	input wire logic [7:0] route, // Selected input
	output logic x_minus, // X-minus level
	output logic x_plus, // X-plus level
	output logic [9:0] sample // Converter word
);
	initial {x_minus, x_plus, sample} = '0;
	always @(posedge mclk) begin
		x_minus <= ~pen_down;
		x_plus <= ~pen_down;
		// Word names the routed input; garbage while powered down
		sample <= power_on ? {2'b10, route} : ~{2'b10, route};
	end
endmodule

// ==== verif/tac_props.sv ====
// Assertions for the touch panel and converter control block
`timescale 1ns/10ps
module tac_props (
	input wire logic MCLK, // Clock
	input wire logic RST, // Reset
	input wire logic WB_CYC_I, // Cycle
	input wire logic WB_STB_I, // Strobe
	input wire logic [31:0] WB_DAT_O, // Read data
	input wire logic WB_ACK_O, // Acknowledge
	input wire logic IRQ, // Interrupt
	input wire logic CONV_SYNC_PIN, // Sync pin
	input wire logic XPLUS_POWER, // Pin drive
	input wire logic YMINUS_GROUND, // Pin drive
	input wire logic MODE_IRQ, // Mode
	input wire logic MODE_PRESSURE, // Mode
	input wire logic MODE_POSITION, // Mode
	input wire logic CONVERTER_POWER_ON, // Power
	input wire logic [7:0] CONV_INPUT_ONEHOT, // Route
	input wire logic REFERENCE_BYPASS_EN, // Bypass
	input wire logic CONV_SAMPLE_REQ // Converting
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	AST_ACK_REQ: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I & WB_STB_I))
		else $error("ack without request");
	AST_DAT_HI: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_MODE: assert property ($onehot({MODE_IRQ, MODE_PRESSURE, MODE_POSITION}))
		else $error("panel mode not one-hot");
	AST_ROUTE: assert property ($onehot(CONV_INPUT_ONEHOT))
		else $error("input route not one-hot");
	AST_PIN: assert property ($changed({XPLUS_POWER, YMINUS_GROUND}) |-> WB_ACK_O)
		else $error("pin drive changed without write");
	AST_BYP: assert property ($changed(REFERENCE_BYPASS_EN) |-> WB_ACK_O)
		else $error("bypass changed without write");
	AST_PWR: assert property (CONV_SAMPLE_REQ |-> CONVERTER_POWER_ON)
		else $error("converting while powered down");
	AST_LEN: assert property ($rose(CONV_SAMPLE_REQ) |->
		CONV_SAMPLE_REQ [*8] ##12 !CONV_SAMPLE_REQ)
		else $error("conversion length wrong");
	AST_GO: assert property ($rose(CONV_SAMPLE_REQ) |->
		$past(WB_ACK_O) || $past(CONV_SYNC_PIN))
		else $error("conversion began without cause");
	COV_CONV: cover property ($rose(CONV_SAMPLE_REQ));
	COV_IRQ: cover property ($rose(IRQ));
	COV_POS: cover property (MODE_POSITION);
endmodule
bind tac_touch_adc_control tac_props tac_props_inst (.*);

// ==== verif/tb.sv ====
// Self-checking bench for the touch panel and converter control block
`timescale 1ns/10ps
module tb import tac_pkg::*;;
	logic MCLK = 0, RST = 1, pen = 1, sync = 0, ovr = 0, sat = 0;
	logic [9:0] gpio = 10'h000, smp;
	tac_wb_req_t rq = '0;
	logic [31:0] rdat;
	logic ack, irq, xm, xp, req, pwr, byp, tst;
	logic [7:0] oh;
	logic [12:0] outs;
	logic [15:0] r, w;
	int n_errors = 0, checks = 0, cyc_n = 0;
	logic [28:0] rows [5] = '{{16'h0800, 13'h1400}, {16'h0500, 13'h0a00},
		{16'h02a5, 13'h01a5}, {16'h035a, 13'h015a}, {16'h00ff, 13'h04ff}};
	logic [9:0] adrs [8] = '{ADR_IRQ_STATUS, ADR_PANEL_CTRL, ADR_CONV_CTRL,
		ADR_CONV_RESULT, ADR_POS_EDGE_EN, ADR_NEG_EDGE_EN, ADR_IRQ_MASK, 10'h3fc};
	always #4 MCLK = ~MCLK;
	tac_touch_adc_control tac_touch_adc_control_inst (.MCLK(MCLK), .RST(RST),
		.WB_CYC_I(rq.cyc), .WB_STB_I(rq.stb), .WB_WE_I(rq.we), .WB_SEL_I(rq.sel),
		.WB_ADR_I(rq.adr), .WB_DAT_I(rq.dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.IRQ(irq), .X_MINUS_PIN_LVL(xm), .X_PLUS_PIN_LVL(xp), .CONVERTER_OVERRANGE(ovr),
		.AUDIO_SATURATION(sat), .GPIO_LVL(gpio), .CONV_SYNC_PIN(sync), .CONV_SAMPLE(smp),
		.YPLUS_GROUND(outs[7]), .YMINUS_GROUND(outs[6]), .XPLUS_GROUND(outs[5]),
		.XMINUS_GROUND(outs[4]), .YPLUS_POWER(outs[3]), .YMINUS_POWER(outs[2]),
		.XPLUS_POWER(outs[1]), .XMINUS_POWER(outs[0]), .PANEL_BIAS_EN(outs[12]),
		.SCHMITT_HYST_OFF(outs[11]), .MODE_IRQ(outs[10]), .MODE_PRESSURE(outs[9]),
		.MODE_POSITION(outs[8]), .CONVERTER_POWER_ON(pwr), .CONV_INPUT_ONEHOT(oh),
		.REFERENCE_BYPASS_EN(byp), .TEST_EXT_VOLTAGE(tst), .CONV_SAMPLE_REQ(req));
	tac_panel_model tac_panel_model_inst (.mclk(MCLK), .pen_down(pen), .power_on(pwr),
		.route(oh), .x_minus(xm), .x_plus(xp), .sample(smp));
	task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task wb(input logic we, input logic [9:0] a, input logic [15:0] d);
		@(posedge MCLK);
		rq <= '{1'b1, 1'b1, we, 4'h3, a, {16'h0000, d}};
		do @(posedge MCLK); while (ack !== 1'b1);
		r = rdat[15:0];
		rq <= '0;
	endtask
	task wait_done;
		repeat (20) begin
			wb(1'b0, ADR_CONV_RESULT, 16'h0000);
			if (r[15] === 1'b1) break;
		end
	endtask
	task results;
		$display("mismatches %0d comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_errors++;
			results;
		end
	end
	initial begin
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		foreach (rows[i]) begin
			wb(1'b1, ADR_PANEL_CTRL, rows[i][28:13]);
			chk("panel outs", 16'(outs), 16'(rows[i][12:0]));
			wb(1'b0, ADR_PANEL_CTRL, 16'h0000);
			chk("panel read", r, rows[i][28:13]);
		end
		$display("register rows done");
		wb(1'b1, ADR_CONV_CTRL, 16'h8000);
		chk("power on", 16'(pwr), 16'h0001);
		for (int i = 0; i < 8; i++) begin
			w = 16'h8000 | 16'(i * 4 + i % 2 * 2);
			wb(1'b1, ADR_CONV_CTRL, w | 16'h0080);
			chk("route", 16'(oh), 16'(1 << i));
			chk("bypass", 16'(byp), 16'(i % 2));
			chk("test bit", 16'(tst), 16'h0000);
			wb(1'b0, ADR_CONV_RESULT, 16'h0000);
			chk("busy", 16'(r[15]), 16'h0000);
			wait_done;
			chk("result", r, 16'h8200 | 16'(1 << i));
			wb(1'b0, ADR_CONV_CTRL, 16'h0000);
			chk("go clear", r, w);
		end
		wb(1'b1, ADR_CONV_CTRL, 16'h8081);
		repeat (30) @(posedge MCLK);
		wb(1'b0, ADR_CONV_CTRL, 16'h0000);
		chk("armed", r, 16'h8081);
		wb(1'b0, ADR_CONV_RESULT, 16'h0000);
		chk("held", r, 16'h8280);
		sync <= 1'b1;
		repeat (3) @(posedge MCLK);
		wait_done;
		chk("sync result", r, 16'h8201);
		sync <= 1'b0;
		$display("conversions done");
		wb(1'b1, ADR_POS_EDGE_EN, 16'hd801);
		wb(1'b1, ADR_NEG_EDGE_EN, 16'h2000);
		ovr <= 1'b1;
		sat <= 1'b1;
		gpio <= 10'h001;
		pen <= 1'b0;
		repeat (4) @(posedge MCLK);
		wb(1'b0, ADR_IRQ_STATUS, 16'h0000);
		chk("rise status", r, 16'hd001);
		chk("masked irq", 16'(irq), 16'h0000);
		wb(1'b0, ADR_PANEL_CTRL, 16'h0000);
		chk("pen up", r, 16'h30ff);
		wb(1'b1, ADR_IRQ_MASK, 16'hffff);
		repeat (2) @(posedge MCLK);
		chk("irq on", 16'(irq), 16'h0001);
		wb(1'b1, ADR_IRQ_STATUS, 16'h5000);
		wb(1'b0, ADR_IRQ_STATUS, 16'h0000);
		chk("part clear", r, 16'h8001);
		wb(1'b1, ADR_IRQ_STATUS, 16'h8001);
		repeat (2) @(posedge MCLK);
		chk("irq off", 16'(irq), 16'h0000);
		pen <= 1'b1;
		ovr <= 1'b0;
		gpio <= 10'h000;
		repeat (4) @(posedge MCLK);
		wb(1'b0, ADR_IRQ_STATUS, 16'h0000);
		chk("fall status", r, 16'h2000);
		wb(1'b1, ADR_IRQ_STATUS, 16'h2000);
		wb(1'b1, ADR_CONV_CTRL, 16'h8080);
		wait_done;
		wb(1'b0, ADR_IRQ_STATUS, 16'h0000);
		chk("ready status", r, 16'h0800);
		wb(1'b1, ADR_CONV_CTRL, 16'h0000);
		chk("power off", 16'(pwr), 16'h0000);
		$display("interrupts done");
		RST <= 1'b1;
		repeat (2) @(posedge MCLK);
		RST <= 1'b0;
		chk("reset outs", 16'(outs), 16'h0400);
		foreach (adrs[i]) begin
			wb(1'b0, adrs[i], 16'h0000);
			chk("reset read", r, 16'h0000);
		end
		$display("reset done");
		results;
	end
endmodule
